/* mbs_defines.vh */
// Port addresses, field positions, option codes and reset values for the memory controller
`ifndef MBS_DEFINES_VH
`define MBS_DEFINES_VH
`define MBS_PORT_NET 8'h3f
`define MBS_PORT_BANK 8'h7f
`define MBS_PORT_DIALER 8'h1e
`define MBS_PORT_EXP2 8'h4f
`define MBS_PORT_MODEM_DATA 8'h5e
`define MBS_PORT_MODEM_CTRL 8'h5f
`define MBS_PORT_CONSOLE_MSB 7
`define MBS_LO_LSB 0
`define MBS_LO_MSB 1
`define MBS_HI_LSB 2
`define MBS_HI_MSB 3
`define MBS_NET_RST_BIT 0
`define MBS_ROM_EN_BIT 1
`define MBS_LO_BOOT 2'h0
`define MBS_LO_IRAM 2'h1
`define MBS_LO_XRAM 2'h2
`define MBS_LO_GAME 2'h3
`define MBS_HI_IRAM 2'h0
`define MBS_HI_XROM 2'h1
`define MBS_HI_XRAM 2'h2
`define MBS_HI_CART 2'h3
`define MBS_BANK_RESET 4'h0
`define MBS_NET_RESET 2'h0
`define MBS_GAME_ROM_TOP 16'h1fff
`endif

/* mbs_port_decode.v */
// Fixed I/O port address decoder
`timescale 1ns/1ns
`include "mbs_defines.vh"
module mbs_port_decode
(
	input wire [7:0] portAddr,
	input wire ioCycle,
	output wire selNet,
	output wire selBank,
	output wire selDialer,
	output wire selExp2,
	output wire selModemData,
	output wire selModemCtrl,
	output wire selConsole
);
	// One-hot selects; reserved ports select nothing
	assign selNet = ioCycle && (portAddr == `MBS_PORT_NET);
	assign selBank = ioCycle && (portAddr == `MBS_PORT_BANK);
	assign selDialer = ioCycle && (portAddr == `MBS_PORT_DIALER); // [RQ16]
	assign selExp2 = ioCycle && (portAddr == `MBS_PORT_EXP2); // [RQ16]
	assign selModemData = ioCycle && (portAddr == `MBS_PORT_MODEM_DATA); // [RQ16]
	assign selModemCtrl = ioCycle && (portAddr == `MBS_PORT_MODEM_CTRL); // [RQ16]
	// Upper half of I/O space goes to console functions [RQ17]
	assign selConsole = ioCycle && portAddr[`MBS_PORT_CONSOLE_MSB];
endmodule

/* mbs_region_map.v */
// Combinational memory source steering for both 32K halves
`timescale 1ns/1ns
`include "mbs_defines.vh"
module mbs_region_map
(
	input wire [15:0] memAddr,
	input wire memCycle,
	input wire [1:0] loSel,
	input wire [1:0] hiSel,
	input wire romEnable,
	output reg selWordRom,
	output reg selOsRom,
	output reg selGameRom,
	output reg selIntRam,
	output reg selExpRam,
	output reg selExpRom,
	output reg selCart,
	output reg ramA15
)
;
	// Address bit 15 picks the half, each half decoded on its own code [RQ1]
	always @*
	begin
		selWordRom = 1'b0;
		selOsRom = 1'b0;
		selGameRom = 1'b0;
		selIntRam = 1'b0;
		selExpRam = 1'b0;
		selExpRom = 1'b0;
		selCart = 1'b0;
		ramA15 = memAddr[15];
		if (memCycle && !memAddr[15])
		begin
			case (loSel) // [RQ4]
			`MBS_LO_BOOT:
			begin
				// OS ROM only overlays while boot ROMs are mapped [RQ14] [RQ15]
				selOsRom = romEnable;
				selWordRom = !romEnable;
			end
			`MBS_LO_IRAM: selIntRam = 1'b1; // [RQ7]
			`MBS_LO_XRAM: selExpRam = 1'b1; // [RQ9]
			`MBS_LO_GAME:
			begin
				// 8K game ROM at bottom, 24K internal RAM above [RQ10]
				selGameRom = (memAddr <= `MBS_GAME_ROM_TOP);
				selIntRam = (memAddr > `MBS_GAME_ROM_TOP);
			end
			default: selIntRam = 1'b0;
			endcase
		end
		else if (memCycle)
		begin
			case (hiSel) // [RQ5]
			`MBS_HI_IRAM: selIntRam = 1'b1; // [RQ7]
			`MBS_HI_XROM: selExpRom = 1'b1; // [RQ11]
			`MBS_HI_XRAM: selExpRam = 1'b1; // [RQ9]
			`MBS_HI_CART: selCart = 1'b1; // [RQ12]
			default: selCart = 1'b0;
			endcase
		end
	end
endmodule

/* mbs_memory_io_controller.v */
// Memory and I/O controller: bank port, network port, memory and port decode
// Functional notes
// RQ1: Two independent 32K halves of 64K space
// RQ2: Bank choice made through one write port
// RQ3: Bits 1:0 lower, 3:2 upper, rest reserved
// RQ4: Lower codes: boot ROM, RAM, expansion, game
// RQ5: Upper codes: RAM, expansion ROM, expansion RAM, cartridge
// RQ6: Reset selects boot ROM low, RAM high
// RQ7: Internal RAM halves follow selected half
// RQ8: Network DMA buffers only in internal RAM
// RQ9: Expansion RAM halves follow selected half
// RQ10: Game ROM 8K plus 24K internal RAM
// RQ11: Upper expansion ROM from connector two
// RQ12: Upper cartridge option routes to cartridge slot
// RQ13: Network port bit 0 drives network reset
// RQ14: Network port bit 1 enables OS ROM
// RQ15: OS ROM enable acts only with boot ROM
// RQ16: Decode dialer, connector two, modem ports
// RQ17: Ports 80 to FF left to console
// RQ18: Network port clears on reset
`timescale 1ns/1ns
`include "mbs_defines.vh"
module mbs_memory_io_controller
(
	// Clock and asynchronous reset
	input wire sys_clk,
	input wire rstn,
	// Host bus, strobes active low
	input wire [15:0] addr,
	input wire [7:0] dataIn,
	input wire ioReqN,
	input wire memReqN,
	input wire wrN,
	input wire computerResetN,
	// Network reset line
	output reg netResetN,
	// Memory chip selects, valid while memReqN is low
	output wire selWordRom,
	output wire selOsRom,
	output wire selGameRom,
	output wire selIntRam,
	output wire selExpRam,
	output wire selExpRom,
	output wire selCart,
	output wire ramA15,
	// I/O port selects, valid while ioReqN is low
	output wire selDialer,
	output wire selExp2,
	output wire selModemData,
	output wire selModemCtrl,
	output wire selConsole,
	// Port register contents
	output wire [1:0] lowerSel,
	output wire [1:0] upperSel,
	output wire osRomEnable
);
	// Widths of the two write-only port registers; other data bits are dropped
	localparam BANK_BITS = 4;
	localparam NET_BITS = 2;
	// Values forced by power-up and by the computer-reset switch
	localparam [BANK_BITS-1:0] BANK_RESET = `MBS_BANK_RESET;
	localparam [NET_BITS-1:0] NET_RESET = `MBS_NET_RESET;
	// Lower code under which the OS ROM overlay may act
	localparam [1:0] LO_BOOT = `MBS_LO_BOOT;

	// Memory map, one code per 32K half:
	// Lower 00 boot and word-processor ROMs, OS ROM overlay when enabled
	// Lower 01 lower internal RAM, the place for network DMA buffers
	// Lower 10 lower expansion RAM
	// Lower 11 8K game ROM, then 24K internal RAM
	// Upper 00 upper internal RAM
	// Upper 01 ROM in expansion connector two
	// Upper 10 upper expansion RAM
	// Upper 11 cartridge slot
	// Expansion options assume the boards are fitted; nothing checks presence
	// Reserved bank bits 7:4 are ignored rather than checked

	// Both port registers are write-only; this block returns no read data
	// Bank port register: upper code above lower code
	reg [BANK_BITS-1:0] bank_reg;
	reg [BANK_BITS-1:0] bank_next;
	// Network port register: ROM enable above network reset bit
	reg [NET_BITS-1:0] net_reg;
	reg [NET_BITS-1:0] net_next;
	// High while the present write strobe has already been taken
	reg wrDone_reg;
	reg wrDone_next;
	// Next value of the registered network reset line
	reg netResetN_next;
	// Write steering and ROM overlay gate
	reg bankWrite;
	reg netWrite;
	reg romOverlay;

	// Bus cycle qualifiers
	wire ioCycle;
	wire memCycle;
	wire ioWrite;
	wire writeEdge;
	wire mapForce;
	// Port selects kept inside this block
	wire selNet;
	wire selBank;
	// Register fields as seen by the memory steering
	wire [1:0] loCode;
	wire [1:0] hiCode;
	wire romGate;

	// Host strobes are active low and taken as synchronous to sys_clk
	assign ioCycle = !ioReqN;
	assign memCycle = !memReqN;
	// Only I/O write cycles and the resets can change the map; memory writes never do
	assign ioWrite = ioCycle && !wrN;
	// One update per write cycle, however long the strobe stays low
	assign writeEdge = ioWrite && !wrDone_reg;
	// The switch wins over a write that lands in the same cycle [RQ6]
	assign mapForce = !computerResetN;

	// Fixed I/O port decode; reserved ports raise no select [RQ17]
	mbs_port_decode uDecode
	(
		.portAddr(addr[7:0]),
		.ioCycle(ioCycle),
		.selNet(selNet),
		.selBank(selBank),
		.selDialer(selDialer),
		.selExp2(selExp2),
		.selModemData(selModemData),
		.selModemCtrl(selModemCtrl),
		.selConsole(selConsole)
	);

	// Write steering: at most one port register takes a given strobe
	// The two port addresses never decode together, so both cannot load
	always @*
	begin
		bankWrite = 1'h0;
		netWrite = 1'h0;
		if (writeEdge)
		begin
			bankWrite = selBank; // [RQ2]
			netWrite = selNet; // [RQ13]
		end
	end

	// Strobe tracker follows the write strobe level
	always @*
	begin
		wrDone_next = ioWrite;
	end

	// Strobe tracker; a long strobe cannot write twice
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wrDone_reg <= 1'h0;
		end
		else
		begin
			wrDone_reg <= wrDone_next;
		end
	end

	// Bank next value; reserved bits 7:4 never reach the register [RQ3]
	always @*
	begin
		bank_next = bank_reg;
		case ({mapForce, bankWrite})
		2'h0:
		begin
			bank_next = bank_reg;
		end
		2'h1:
		begin
			bank_next = dataIn[`MBS_HI_MSB:`MBS_LO_LSB]; // [RQ2] [RQ3]
		end
		default:
		begin
			bank_next = BANK_RESET; // [RQ6] switch beats a write
		end
		endcase
	end

	// One flip-flop per bank bit; power-up gives boot ROM low, RAM high [RQ6]
	genvar bankBit;
	generate
		for (bankBit = 0; bankBit < BANK_BITS; bankBit = bankBit + 1)
		begin : gen_bank_bit
			always @(posedge sys_clk or negedge rstn)
			begin
				if (!rstn)
				begin
					bank_reg[bankBit] <= BANK_RESET[bankBit]; // [RQ6]
				end
				else
				begin
					bank_reg[bankBit] <= bank_next[bankBit];
				end
			end
		end
	endgenerate

	// Network port next value; the switch clears it as well [RQ18]
	always @*
	begin
		net_next = net_reg;
		case ({mapForce, netWrite})
		2'h0:
		begin
			net_next = net_reg;
		end
		2'h1:
		begin
			net_next = dataIn[`MBS_ROM_EN_BIT:`MBS_NET_RST_BIT]; // [RQ13] [RQ14]
		end
		default:
		begin
			net_next = NET_RESET; // [RQ18]
		end
		endcase
	end

	// One flip-flop per network port bit; reset leaves the net running [RQ18]
	genvar netBit;
	generate
		for (netBit = 0; netBit < NET_BITS; netBit = netBit + 1)
		begin : gen_net_bit
			always @(posedge sys_clk or negedge rstn)
			begin
				if (!rstn)
				begin
					net_reg[netBit] <= NET_RESET[netBit]; // [RQ18]
				end
				else
				begin
					net_reg[netBit] <= net_next[netBit];
				end
			end
		end
	endgenerate

	// Network reset line next value, low while bit 0 is set [RQ13]
	always @*
	begin
		netResetN_next = !net_reg[`MBS_NET_RST_BIT]; // [RQ13]
	end

	// Registered line: a flop output cannot glitch while the decode settles
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			netResetN <= 1'h1;
		end
		else
		begin
			netResetN <= netResetN_next;
		end
	end

	// Register fields [RQ3]
	assign loCode = bank_reg[`MBS_LO_MSB:`MBS_LO_LSB]; // [RQ3]
	assign hiCode = bank_reg[`MBS_HI_MSB:`MBS_HI_LSB]; // [RQ3]
	assign romGate = net_reg[`MBS_ROM_EN_BIT]; // [RQ14]
	// Port contents are also brought out so the host side can be observed
	assign lowerSel = loCode;
	assign upperSel = hiCode;
	assign osRomEnable = romGate;

	// Overlay only under the boot ROM option; elsewhere the enable is inert [RQ15]
	always @*
	begin
		romOverlay = 1'h0;
		case (loCode)
		LO_BOOT:
		begin
			romOverlay = romGate; // [RQ15]
		end
		default:
		begin
			romOverlay = 1'h0;
		end
		endcase
	end

	// Memory steering; network DMA relies on software keeping buffers in internal RAM [RQ8]
	mbs_region_map uMap
	(
		.memAddr(addr),
		.memCycle(memCycle),
		.loSel(loCode),
		.hiSel(hiCode),
		.romEnable(romOverlay),
		.selWordRom(selWordRom),
		.selOsRom(selOsRom),
		.selGameRom(selGameRom),
		.selIntRam(selIntRam),
		.selExpRam(selExpRam),
		.selExpRom(selExpRom),
		.selCart(selCart),
		.ramA15(ramA15)
	);
endmodule

/* mbs_io_check_monitor.sv */
// Assertion checker for the memory and I/O controller ports
`timescale 1ns/1ns
module mbs_io_check
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic ioReqN,
	input wire logic memReqN,
	input wire logic wrN,
	input wire logic computerResetN,
	input wire logic netResetN,
	input wire logic selWordRom,
	input wire logic selOsRom,
	input wire logic selGameRom,
	input wire logic selIntRam,
	input wire logic osRomEnable,
	input wire logic [15:0] addr,
	input wire logic [7:0] dataIn,
	input wire logic [1:0] lowerSel,
	input wire logic [1:0] upperSel
);
	logic prevW;
	wire logic take = !ioReqN && !wrN && !prevW && computerResetN;
	wire logic wb = take && addr[7:0] == 8'h7f;
	wire logic wn = take && addr[7:0] == 8'h3f;
	wire logic lo0 = !memReqN && !addr[15];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// Strobe history, so a held write is counted once only
	always @(posedge sys_clk or negedge rstn)
		if (!rstn)
			prevW <= 1'b0;
		else
			prevW <= !ioReqN && !wrN;
	chk_bank_write: assert property (wb |=> {upperSel, lowerSel} == $past(dataIn[3:0]))
		else $error("bank port not loaded");
	chk_net_write: assert property (wn |=> osRomEnable == $past(dataIn[1]))
		else $error("rom enable not loaded");
	chk_net_line: assert property (wn |-> ##2 netResetN == !$past(dataIn[0], 2))
		else $error("network reset line wrong");
	chk_comp_reset: assert property (!computerResetN |=> {upperSel, lowerSel, osRomEnable} == 5'h00)
		else $error("computer reset map wrong");
	chk_bank_hold: assert property (!wb && computerResetN |=> $stable({upperSel, lowerSel}))
		else $error("bank changed without write");
	chk_os_swap: assert property (lo0 && lowerSel == 2'h0 |-> selOsRom == osRomEnable && selWordRom != osRomEnable)
		else $error("rom swap wrong");
	chk_os_blocked: assert property (lowerSel != 2'h0 |-> !selOsRom && !selWordRom)
		else $error("boot rom outside its option");
	chk_game_split: assert property (lo0 && lowerSel == 2'h3 |-> selGameRom == (addr < 16'h2000) && selIntRam == !selGameRom)
		else $error("game split wrong");
	cover property (wn);
	cover property (lo0 && selGameRom);
	cover property (!computerResetN);
endmodule

/* mbs_host_model.sv */
// Host processor model issuing memory and I/O bus cycles
`timescale 1ns/1ns
module mbs_host_model
(
	input wire logic sys_clk,
	output logic [15:0] addr = 16'h0000,
	output logic [7:0] dataIn = 8'h00,
	output logic ioReqN = 1'b1,
	output logic memReqN = 1'b1,
	output logic wrN = 1'b1,
	output logic probe = 1'b0
);
	// One cycle, then an idle edge; the host changes banks only by port writes
	task cyc(input logic io, input logic wr, input logic [15:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		{addr, dataIn} = {a, d};
		{ioReqN, memReqN, wrN, probe} = {!io, io, !wr, !wr};
		@(negedge sys_clk);
		{ioReqN, memReqN, wrN, probe} = 4'he;
		{addr, dataIn} = ~{a, d}; // Stale bus never matches
	endtask
endmodule

/* testbench.sv */
// Self-checking bench for the memory and I/O controller
`timescale 1ns/1ns
module testbench;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic computerResetN = 1'b1;
	logic [1:0] lo = 2'h0, hi = 2'h0;
	logic os = 1'b0, nr = 1'b1;
	logic [14:0] q[$];
	logic [31:0] r;
	logic [7:0] ports[5] = '{8'h1e, 8'h4f, 8'h5e, 8'h5f, 8'h9a};
	int fail_count = 0, check_count = 0;
	wire [15:0] addr;
	wire [7:0] dataIn;
	wire ioReqN, memReqN, wrN, probe;
	wire [14:0] obs;
	always #5 sys_clk = !sys_clk;
	mbs_host_model i_mbs_host_model (.sys_clk(sys_clk), .addr(addr), .dataIn(dataIn),
		.ioReqN(ioReqN), .memReqN(memReqN), .wrN(wrN), .probe(probe));
	mbs_memory_io_controller i_mbs_memory_io_controller (.sys_clk(sys_clk), .rstn(rstn),
		.addr(addr), .dataIn(dataIn), .ioReqN(ioReqN), .memReqN(memReqN), .wrN(wrN),
		.computerResetN(computerResetN), .selWordRom(obs[14]), .selOsRom(obs[13]),
		.selGameRom(obs[12]), .selIntRam(obs[11]), .selExpRam(obs[10]), .selExpRom(obs[9]),
		.selCart(obs[8]), .ramA15(obs[7]), .selDialer(obs[6]), .selExp2(obs[5]),
		.selModemData(obs[4]), .selModemCtrl(obs[3]), .selConsole(obs[2]),
		.netResetN(obs[1]), .osRomEnable(obs[0]), .lowerSel(), .upperSel());
	// Expected selects from the tracked port contents
	function automatic logic [14:0] model(input logic [15:0] a, input logic io);
		logic [7:0] m;
		logic [4:0] p;
		logic g;
		p = {a[7:0] == 8'h1e, a[7:0] == 8'h4f, a[7:0] == 8'h5e, a[7:0] == 8'h5f, a[7]};
		g = lo == 2'h3 && a < 16'h2000;
		m = {lo == 2'h0 && !os, lo == 2'h0 && os, g, lo == 2'h1 || (lo == 2'h3 && !g), lo == 2'h2, 3'h0};
		if (a[15])
			m = {3'h0, hi == 2'h0, hi == 2'h2, hi == 2'h1, hi == 2'h3, 1'b1};
		return {io ? {7'h00, a[15]} : m, io ? p : 5'h00, nr, os};
	endfunction
	task wr(input logic [7:0] p, input logic [7:0] d);
		i_mbs_host_model.cyc(1'b1, 1'b1, {r[31:24], p}, d);
		if (p == 8'h7f)
			{hi, lo} = d[3:0];
		if (p == 8'h3f)
			{os, nr} = {d[1], !d[0]};
	endtask
	task rd(input logic io, input logic [15:0] a);
		q.push_back(model(a, io));
		i_mbs_host_model.cyc(io, 1'b0, a, r[7:0]);
	endtask
	task cmp(input logic [14:0] e, input logic [14:0] s);
		check_count++;
		if (e !== s)
		begin
			fail_count++;
			$display("Error selects expected %h seen %h", e, s);
		end
	endtask
	task summarize;
		$display("Checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Oldest note against each probed cycle
	always @(posedge sys_clk)
		if (probe)
			cmp(q.pop_front(), obs);
	// Watchdog, far beyond the few hundred cycles needed
	initial
	begin
		#20000;
		fail_count++;
		summarize();
	end
	// Main sequence
	initial
	begin
		r = $urandom(32'h2b717553);
		repeat (6) @(negedge sys_clk);
		rstn = 1'b1;
		rd(1'b0, 16'h0000);
		rd(1'b0, 16'h8000);
		for (int i = 0; i < 16; i++)
		begin
			r = $urandom;
			wr(8'h7f, i[7:0]);
			rd(1'b0, {1'b0, r[14:0]});
			rd(1'b0, {1'b1, r[30:16]});
			rd(1'b0, 16'h1fff);
			rd(1'b0, 16'h2000);
		end
		wr(8'h7f, 8'h01);
		rd(1'b0, {2'h1, r[13:0]});
		rd(1'b0, {1'b1, r[14:0]});
		wr(8'h7f, 8'h00);
		wr(8'h3f, 8'h03);
		rd(1'b0, 16'h0100);
		wr(8'h7f, 8'h01);
		rd(1'b0, 16'h0100);
		wr(8'h3f, 8'h00);
		wr(8'h7f, 8'h00);
		rd(1'b0, 16'h0100);
		foreach (ports[k])
			rd(1'b1, {r[15:8], ports[k]});
		wr(8'h7f, 8'h0f);
		wr(8'h3f, 8'h02);
		@(negedge sys_clk) computerResetN = 1'b0;
		@(negedge sys_clk) computerResetN = 1'b1;
		{hi, lo, os, nr} = 6'h01;
		rd(1'b0, 16'h0000);
		rd(1'b0, 16'h8000);
		summarize();
	end
endmodule
bind mbs_memory_io_controller mbs_io_check i_mbs_io_check
(
	.sys_clk(sys_clk),
	.rstn(rstn),
	.ioReqN(ioReqN),
	.memReqN(memReqN),
	.wrN(wrN),
	.computerResetN(computerResetN),
	.netResetN(netResetN),
	.selWordRom(selWordRom),
	.selOsRom(selOsRom),
	.selGameRom(selGameRom),
	.selIntRam(selIntRam),
	.osRomEnable(osRomEnable),
	.addr(addr),
	.dataIn(dataIn),
	.lowerSel(lowerSel),
	.upperSel(upperSel)
);
